// ### rtl/ocds_pkg.sv
// Shared constants, channel maps and helper functions for the output channel block
`default_nettype none
package ocds_pkg;

	// Channel and divider counts
	localparam int NUM_CH = 16;
	localparam int NUM_CD = 11;
	localparam int NUM_SD = 7;

	// Divider and delay widths
	localparam int CD_W    = 12;
	localparam int SD_W    = 20;
	localparam int DLY_W   = 8;
	localparam int SDDLY_W = 3;
	localparam int ANALOG_DELAY_STAGE_W  = 2;

	// SYSREF request control register
	localparam logic [7:0] REQ_CTRL_ADDR  = 8'h1a;
	localparam logic [7:0] REQ_CTRL_RESET = 8'h00;
	localparam int         REQ_MODE_LSB   = 4;
	localparam int         REQ_MODE_MSB   = 5;
	localparam int         REQ_SEL_LSB    = 2;
	localparam int         REQ_SEL_MSB    = 3;
	localparam logic [1:0] REQ_MODE_RESAMPLE = 2'h3;
	localparam logic [1:0] REQ_SEL_SOURCE    = 2'h0;

	// Channel mux codes
	localparam logic [2:0] CM_BYPASS      = 3'h0;
	localparam logic [2:0] CM_CHANNEL_DIVIDER_TAP = 3'h1;
	localparam logic [2:0] CM_CH_HALF     = 3'h2;
	localparam logic [2:0] CM_SYSREF      = 3'h3;
	localparam logic [2:0] CM_SYSREF_ANALOG_DELAY_STAGE = 3'h4;
	localparam logic [2:0] CM_STATIC_DC   = 3'h5;

	// Channel divider serving a channel
	function automatic int cdIndex(input int ch);
		if (ch < 4)
			return ch;
		if (ch < 14)
			return (ch - 4) / 2 + 4;
		return ch - 14 + 9;
	endfunction

	function automatic bit hasSd(input int ch);
		return (ch < 2) || ((ch >= 4) && (ch < 14));
	endfunction

	function automatic int sdIndex(input int ch);
		return (ch < 2) ? ch : (ch - 4) / 2 + 2;
	endfunction

	// Channel divider feeding a SYSREF divider
	function automatic int sdToCd(input int j);
		return (j < 2) ? j : j + 2;
	endfunction

	// Channels whose drivers keep a channel divider powered
	function automatic logic [NUM_CH-1:0] cdChanMask(input int i);
		logic [NUM_CH-1:0] m;
		m = '0;
		for (int c = 0; c < NUM_CH; c++)
		begin
			if (cdIndex(c) == i)
				m[c] = 1'h1;
		end
		return m;
	endfunction

endpackage
`default_nettype wire

// ### rtl/ocds_tap_if.sv
// Clock tap carrier: source or divided level plus its rising-edge pulse
`default_nettype none
interface ocds_tap_if;
	logic level;
	logic rise;
	modport src (output level, output rise);
	modport snk (input level, input rise);
endinterface
`default_nettype wire

// ### rtl/ocds_divider.sv
// Programmable clock divider with start delay and glitch-free reload
`default_nettype none
module ocds_divider #(
	parameter int W = 12
) (
	// Clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       arst_n,
	// Control
	input  wire logic                       enable,
	input  wire logic                       restart,
	input  wire logic [W-1:0]               ratio,
	input  wire logic [ocds_pkg::DLY_W-1:0] startDelay,
	// Clock in and out
	ocds_tap_if.snk                         inTap,
	ocds_tap_if.src                         outTap
);
	import ocds_pkg::*;

	logic [W-1:0]     cnt_reg;
	logic [W-1:0]     cnt_next;
	logic [W-1:0]     shadow_reg;
	logic [W-1:0]     shadow_next;
	logic [DLY_W-1:0] dly_reg;
	logic [DLY_W-1:0] dly_next;
	logic             running_reg;
	logic             running_next;
	logic             level_reg;
	logic             level_next;
	logic             rise_reg;

	wire logic         hold    = ~enable | restart;
	wire logic         divOne  = shadow_reg <= W'(1);
	wire logic         wrap    = cnt_reg == (shadow_reg - W'(1));
	wire logic         step    = running_reg & inTap.rise & ~divOne;
	wire logic [W:0]   halfSum = ({1'h0, shadow_reg} + {{W{1'h0}}, 1'h1}) >> 1;
	wire logic [W-1:0] highCnt = halfSum[W-1:0];
	// While running, new ratio only taken at a period boundary so the output never glitches
	wire logic         reload  = hold | ~running_reg | (inTap.rise & (divOne | wrap));

	// Start delay counts source edges before the first period: static phase offset
	assign dly_next     = hold ? startDelay :
		((~running_reg & inTap.rise & (dly_reg != '0)) ? dly_reg - DLY_W'(1) : dly_reg);
	assign running_next = ~hold & (running_reg | (inTap.rise & (dly_reg == '0)));
	assign cnt_next     = hold ? '0 : (step ? (wrap ? '0 : cnt_reg + W'(1)) : cnt_reg);
	assign shadow_next  = reload ? ratio : shadow_reg;
	// High for the first half of the count: near 50 percent duty
	assign level_next   = (hold | ~running_reg) ? 1'h0 :
		(divOne ? inTap.level : (cnt_next < highCnt));

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_reg     <= '0;
			shadow_reg  <= '0;
			dly_reg     <= '0;
			running_reg <= 1'h0;
			level_reg   <= 1'h0;
			rise_reg    <= 1'h0;
		end
		else
		begin
			cnt_reg     <= cnt_next;
			shadow_reg  <= shadow_next;
			dly_reg     <= dly_next;
			running_reg <= running_next;
			level_reg   <= level_next;
			rise_reg    <= level_next & ~level_reg;
		end
	end

	assign outTap.level = level_reg;
	assign outTap.rise  = rise_reg;

endmodule
`default_nettype wire

// ### rtl/ocds_output_channels.sv
// Output channel dividers, SYSREF dividers, channel muxes and replica pins
`default_nettype none
module ocds_output_channels (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         arst_n,
	// Selected post-divider clock, sampled, and SYSREF request
	input  wire logic                         srcClkLevel,
	input  wire logic                         sysrefRequest,
	// Per channel driver enable and channel mux select
	input  wire logic [ocds_pkg::NUM_CH-1:0]  outputDriverEnable,
	input  wire logic [2:0]                   channelMuxSel [ocds_pkg::NUM_CH],
	// Channel divider settings
	input  wire logic [ocds_pkg::CD_W-1:0]    channelDivideRatio [ocds_pkg::NUM_CD],
	input  wire logic [ocds_pkg::DLY_W-1:0]   channelStaticDelay [ocds_pkg::NUM_CD],
	// SYSREF divider settings
	input  wire logic [ocds_pkg::SD_W-1:0]    sysrefDivideRatio [ocds_pkg::NUM_SD],
	input  wire logic [ocds_pkg::DLY_W-1:0]   sysrefStaticDelay [ocds_pkg::NUM_SD],
	input  wire logic [ocds_pkg::SDDLY_W-1:0] sysrefDigitalDelay [ocds_pkg::NUM_SD],
	input  wire logic [ocds_pkg::ANALOG_DELAY_STAGE_W-1:0]  analogDelayStage [ocds_pkg::NUM_SD],
	// Replica pin settings
	input  wire logic [ocds_pkg::NUM_SD-1:0]  pairSysrefReplicaEnable,
	input  wire logic [1:0]                   generalPinOutputEnable,
	// Register port
	input  wire logic                         regWrEn,
	input  wire logic [7:0]                   regAddr,
	input  wire logic [7:0]                   regWrData,
	output logic      [7:0]                   regRdData,
	// Clock outputs
	output logic      [ocds_pkg::NUM_CH-1:0]  positiveOutputLeg,
	output logic      [ocds_pkg::NUM_CH-1:0]  negativeOutputLeg,
	output logic      [ocds_pkg::NUM_CH-1:0]  outputDriverOe,
	// Replica pins
	output logic                              generalPinOne,
	output logic                              generalPinOneOe,
	output logic                              generalPinTwo,
	output logic                              generalPinTwoOe,
	// Status
	output logic      [ocds_pkg::NUM_CD-1:0]  dividerPowered,
	output logic      [ocds_pkg::NUM_SD-1:0]  sysrefPowered
);
	import ocds_pkg::*;

	// Source edge detect
	// The source clock is sampled as data; its rise is the step for every channel divider
	logic srcPrev_reg;
	wire logic srcRise = srcClkLevel & ~srcPrev_reg;

	ocds_tap_if srcTap ();
	ocds_tap_if cdTap [NUM_CD] ();
	ocds_tap_if sdTap [NUM_SD] ();

	assign srcTap.level = srcClkLevel;
	assign srcTap.rise  = srcRise;

	// Request control register
	// Read data lags the address by one cycle; other addresses read as zero
	logic [7:0] reqCtrl_reg;
	logic [7:0] rdData_reg;
	logic       reqPending_reg;
	wire logic       wrHit      = regWrEn & (regAddr == REQ_CTRL_ADDR);
	wire logic [1:0] reqMode    = reqCtrl_reg[REQ_MODE_MSB:REQ_MODE_LSB];
	wire logic [1:0] reqSel     = reqCtrl_reg[REQ_SEL_MSB:REQ_SEL_LSB];
	wire logic       resampleOn = reqMode == REQ_MODE_RESAMPLE;

	// Per divider state
	// Shift registers give the SYSREF digital and analog delay taps in whole cycles
	wire logic [NUM_CD-1:0] cdPowered;
	wire logic [NUM_SD-1:0] sdPowered;
	wire logic [NUM_SD-1:0] sdDigLevel;
	wire logic [NUM_SD-1:0] sdAnaLevel;
	logic                   half_reg [NUM_CD];
	logic [6:0]             dig_reg  [NUM_SD];
	logic [2:0]             ana_reg  [NUM_SD];

	// Replica priority chain: lowest index active source wins
	wire logic [NUM_SD:0] replFound;
	wire logic [NUM_SD:0] replLevel;
	wire logic [NUM_SD:0] replRise;
	assign replFound[0] = 1'h0;
	assign replLevel[0] = 1'h0;
	assign replRise[0]  = 1'h0;

	// Request edge used to realign all SYSREF dividers
	// One shared restart keeps every SYSREF divider on the same edge
	wire logic sampleRise = (reqSel == REQ_SEL_SOURCE) ? srcRise : replRise[NUM_SD];
	wire logic sdRestart  = resampleOn ? (reqPending_reg & sampleRise) : sysrefRequest;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			srcPrev_reg    <= 1'h0;
			reqCtrl_reg    <= REQ_CTRL_RESET;
			rdData_reg     <= 8'h00;
			reqPending_reg <= 1'h0;
		end
		else
		begin
			srcPrev_reg    <= srcClkLevel;
			reqCtrl_reg    <= wrHit ? regWrData : reqCtrl_reg;
			rdData_reg     <= (regAddr == REQ_CTRL_ADDR) ? reqCtrl_reg : 8'h00;
			// A new request in the firing cycle stays pending
			reqPending_reg <= resampleOn & (sysrefRequest | (reqPending_reg & ~sampleRise));
		end
	end

	assign regRdData = rdData_reg;

	genvar i;
	genvar j;
	genvar c;

	// Channel dividers, each on the source clock
	generate
		for (i = 0; i < NUM_CD; i++)
		begin : g_cd
			// Off when every driver it serves is off
			// Held dividers clear their count, so a re-enable starts a clean period
			assign cdPowered[i] = |(outputDriverEnable & cdChanMask(i));

			ocds_divider #(
				.W(CD_W)
			) u_cd (
				.sys_clk    (sys_clk),
				.arst_n     (arst_n),
				.enable     (cdPowered[i]),
				.restart    (1'h0),
				.ratio      (channelDivideRatio[i]),
				.startDelay (channelStaticDelay[i]),
				.inTap      (srcTap),
				.outTap     (cdTap[i])
			);

			// Fixed divide-by-two of the channel source
			always_ff @(posedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
					half_reg[i] <= 1'h0;
				else if (!cdPowered[i])
					half_reg[i] <= 1'h0;
				else if (srcRise)
					half_reg[i] <= ~half_reg[i];
			end
		end
	endgenerate

	assign dividerPowered = cdPowered;
	assign sysrefPowered  = sdPowered;

	// SYSREF dividers cascaded after their channel divider
	// Each counts rises of its channel divider output, not of the source
	generate
		for (j = 0; j < NUM_SD; j++)
		begin : g_sd
			localparam int CI = sdToCd(j);

			wire logic [7:0] digTaps = {dig_reg[j], sdTap[j].level};
			wire logic [3:0] anaTaps = {ana_reg[j], sdDigLevel[j]};
			wire logic       active  = sdPowered[j] & pairSysrefReplicaEnable[j];

			assign sdPowered[j] = cdPowered[CI];

			// Cascade multiplies the channel ratio by the SYSREF ratio
			ocds_divider #(
				.W(SD_W)
			) u_sd (
				.sys_clk    (sys_clk),
				.arst_n     (arst_n),
				.enable     (sdPowered[j]),
				.restart    (sdRestart),
				.ratio      (sysrefDivideRatio[j]),
				.startDelay (sysrefStaticDelay[j]),
				.inTap      (cdTap[CI]),
				.outTap     (sdTap[j])
			);

			assign sdDigLevel[j] = digTaps[sysrefDigitalDelay[j]];
			assign sdAnaLevel[j] = anaTaps[analogDelayStage[j]];

			always_ff @(posedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					dig_reg[j] <= 7'h00;
					ana_reg[j] <= 3'h0;
				end
				else
				begin
					dig_reg[j] <= {dig_reg[j][5:0], sdTap[j].level};
					ana_reg[j] <= {ana_reg[j][1:0], sdDigLevel[j]};
				end
			end

			// Replica taps the divider output itself: static delay only, no pulser
			assign replFound[j+1] = replFound[j] | active;
			assign replLevel[j+1] = replFound[j] ? replLevel[j] :
				(active & sdTap[j].level);
			assign replRise[j+1]  = replFound[j] ? replRise[j] : (active & sdTap[j].rise);
		end
	endgenerate

	// Replica pins
	// Both pins carry the same replica; only their enables differ
	logic pinOne_reg;
	logic pinOneOe_reg;
	logic pinTwo_reg;
	logic pinTwoOe_reg;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pinOne_reg   <= 1'h0;
			pinOneOe_reg <= 1'h0;
			pinTwo_reg   <= 1'h0;
			pinTwoOe_reg <= 1'h0;
		end
		else
		begin
			pinOne_reg   <= replLevel[NUM_SD];
			pinOneOe_reg <= generalPinOutputEnable[0] & replFound[NUM_SD];
			pinTwo_reg   <= replLevel[NUM_SD];
			pinTwoOe_reg <= generalPinOutputEnable[1] & replFound[NUM_SD];
		end
	end

	assign generalPinOne   = pinOne_reg;
	assign generalPinOneOe = pinOneOe_reg;
	assign generalPinTwo   = pinTwo_reg;
	assign generalPinTwoOe = pinTwoOe_reg;

	// Channel muxes and output legs
	// Registered legs keep a mux change from leaving a runt pulse on the pin
	logic pos_reg [NUM_CH];
	logic neg_reg [NUM_CH];
	logic oe_reg  [NUM_CH];

	generate
		for (c = 0; c < NUM_CH; c++)
		begin : g_ch
			localparam int DI = cdIndex(c);
			localparam bit HS = hasSd(c);
			localparam int SI = HS ? sdIndex(c) : 0;

			wire logic [2:0] sel      = channelMuxSel[c];
			wire logic       sysSel   = (sel == CM_SYSREF) | (sel == CM_SYSREF_ANALOG_DELAY_STAGE);
			// Undefined codes, and SYSREF taps where none exists, rest at static DC
			wire logic       isDc     = (sel >= CM_STATIC_DC) | (sysSel & ~HS);
			wire logic       tapLevel =
				(sel == CM_BYPASS)              ? srcClkLevel :
				(sel == CM_CHANNEL_DIVIDER_TAP) ? cdTap[DI].level :
				(sel == CM_CH_HALF)             ? half_reg[DI] :
				(sel == CM_SYSREF)              ? sdDigLevel[SI] :
				sdAnaLevel[SI];

			always_ff @(posedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					pos_reg[c] <= 1'h0;
					neg_reg[c] <= 1'h1;
					oe_reg[c]  <= 1'h0;
				end
				else
				begin
					pos_reg[c] <= ~isDc & tapLevel;
					neg_reg[c] <= isDc | ~tapLevel;
					oe_reg[c]  <= outputDriverEnable[c];
				end
			end

			assign positiveOutputLeg[c] = pos_reg[c];
			assign negativeOutputLeg[c] = neg_reg[c];
			assign outputDriverOe[c]    = oe_reg[c];
		end
	endgenerate

endmodule
`default_nettype wire

// ### test/ocds_output_channels_assertions.sv
// Port-level concurrent checks for the output channel block
`default_nettype none
module ocds_chk (
	// Clock and reset
	input wire logic                        sys_clk,
	input wire logic                        arst_n,
	// Inputs watched
	input wire logic                        srcClkLevel,
	input wire logic [ocds_pkg::NUM_CH-1:0] outputDriverEnable,
	input wire logic [2:0]                  channelMuxSel [ocds_pkg::NUM_CH],
	input wire logic [ocds_pkg::NUM_SD-1:0] pairSysrefReplicaEnable,
	input wire logic [1:0]                  generalPinOutputEnable,
	input wire logic                        regWrEn,
	input wire logic [7:0]                  regAddr,
	input wire logic [7:0]                  regWrData,
	// Outputs watched
	input wire logic [7:0]                  regRdData,
	input wire logic [ocds_pkg::NUM_CH-1:0] positiveOutputLeg,
	input wire logic [ocds_pkg::NUM_CH-1:0] negativeOutputLeg,
	input wire logic [ocds_pkg::NUM_CH-1:0] outputDriverOe,
	input wire logic                        generalPinOneOe,
	input wire logic [ocds_pkg::NUM_CD-1:0] dividerPowered,
	input wire logic [ocds_pkg::NUM_SD-1:0] sysrefPowered
);
	timeunit 1ns;
	timeprecision 1ns;
	import ocds_pkg::*;
	wire pinOneCause = generalPinOutputEnable[0] & |(sysrefPowered & pairSysrefReplicaEnable);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_wr;
		regWrEn && regAddr == REQ_CTRL_ADDR;
	endsequence
	sequence s_rd;
		!regWrEn && regAddr == REQ_CTRL_ADDR;
	endsequence
	property p_bypass;
		$past(arst_n) && $past(channelMuxSel[0]) == CM_BYPASS |->
			positiveOutputLeg[0] == $past(srcClkLevel) && negativeOutputLeg[0] != $past(srcClkLevel);
	endproperty
	property p_dc;
		$past(arst_n) && $past(channelMuxSel[0]) == CM_STATIC_DC |->
			!positiveOutputLeg[0] && negativeOutputLeg[0];
	endproperty
	property p_nosd;
		$past(arst_n) && $past(channelMuxSel[2]) == CM_SYSREF |->
			!positiveOutputLeg[2] && negativeOutputLeg[2];
	endproperty
	property p_oe;
		$past(arst_n) |-> outputDriverOe == $past(outputDriverEnable);
	endproperty
	property p_pwr01;
		dividerPowered[1:0] == outputDriverEnable[1:0];
	endproperty
	property p_group;
		dividerPowered[4] == (outputDriverEnable[4] | outputDriverEnable[5]);
	endproperty
	property p_pinoe;
		$past(arst_n) |-> generalPinOneOe == $past(pinOneCause);
	endproperty
	property p_reg;
		s_wr ##1 s_rd |=> regRdData == $past(regWrData, 2);
	endproperty
	property p_unmap;
		$past(arst_n) && $past(regAddr) != REQ_CTRL_ADDR |-> regRdData == 8'h00;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass leg mismatch");
	a_dc: assert property (p_dc) else $error("static level wrong");
	a_nosd: assert property (p_nosd) else $error("sysref tap on channel 2");
	a_oe: assert property (p_oe) else $error("driver enable not followed");
	a_pwr01: assert property (p_pwr01) else $error("single divider power");
	a_group: assert property (p_group) else $error("group divider power");
	a_pinoe: assert property (p_pinoe) else $error("replica pin enable");
	a_reg: assert property (p_reg) else $error("register readback");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind ocds_output_channels ocds_chk u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
	.srcClkLevel(srcClkLevel), .outputDriverEnable(outputDriverEnable),
	.channelMuxSel(channelMuxSel), .pairSysrefReplicaEnable(pairSysrefReplicaEnable),
	.generalPinOutputEnable(generalPinOutputEnable), .regWrEn(regWrEn), .regAddr(regAddr),
	.regWrData(regWrData), .regRdData(regRdData), .positiveOutputLeg(positiveOutputLeg),
	.negativeOutputLeg(negativeOutputLeg), .outputDriverOe(outputDriverOe),
	.generalPinOneOe(generalPinOneOe), .dividerPowered(dividerPowered),
	.sysrefPowered(sysrefPowered));
`default_nettype wire

// ### test/ocds_rx_model.sv
// Downstream clock receiver: measures the period of its input in cycles
`default_nettype none
module ocds_rx_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Received clock
	input  wire logic        clkIn,
	// Last measured period
	output logic      [15:0] periodLen
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        prevLevel;
	logic [15:0] cnt;
	always @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prevLevel <= 1'h0;
			cnt       <= 16'h0000;
			periodLen <= 16'h0000;
		end
		else
		begin
			prevLevel <= clkIn;
			cnt       <= (clkIn && !prevLevel) ? 16'h0001 : cnt + 16'h0001;
			if (clkIn && !prevLevel)
				periodLen <= cnt;
		end
	end
endmodule
`default_nettype wire

// ### test/ocds_output_channels_tb_top.sv
// Register and clock-path tests for the output channel block
`default_nettype none
module ocds_output_channels_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ocds_pkg::*;
	logic              sys_clk = 1'h0;
	logic              arst_n = 1'h0;
	logic              srcClkLevel = 1'h0;
	logic              sysrefRequest = 1'h0;
	logic [15:0]       en = 16'hffff;
	logic [2:0]        sel [NUM_CH] = '{default: CM_BYPASS};
	logic [CD_W-1:0]   cdr [NUM_CD] = '{default: 12'h004};
	logic [DLY_W-1:0]  cdd [NUM_CD] = '{default: 8'h00};
	logic [SD_W-1:0]   sdr [NUM_SD] = '{default: 20'h00003};
	logic [DLY_W-1:0]  sdd [NUM_SD] = '{default: 8'h00};
	logic [2:0]        sdg [NUM_SD] = '{default: 3'h0};
	logic [1:0]        adl [NUM_SD] = '{default: 2'h0};
	logic [6:0]        rep = 7'h00;
	logic [1:0]        pinEn = 2'h0;
	logic              regWrEn = 1'h0;
	logic [7:0]        regAddr = 8'h00;
	logic [7:0]        regWrData = 8'h00;
	logic [7:0]        rd;
	logic [15:0]       pos, neg, oe, per0, per1, per2;
	logic [10:0]       dPw;
	logic [6:0]        sPw;
	logic              p1, p1oe, p2, p2oe;
	int                watch = 0;
	int                fail_count = 0;
	int                n_checks = 0;
	int                chs [8] = '{0, 0, 0, 0, 0, 4, 2, 15};
	logic [2:0]        codes [8] = '{CM_BYPASS, CM_CH_HALF, CM_CHANNEL_DIVIDER_TAP, CM_SYSREF,
		CM_SYSREF_ANALOG_DELAY_STAGE, CM_SYSREF, CM_CHANNEL_DIVIDER_TAP, CM_CH_HALF};
	logic [15:0]       exps [8] = '{16'h2, 16'h4, 16'h8, 16'h18, 16'h18, 16'h18, 16'h8, 16'h4};
	always #25 sys_clk = !sys_clk;
	// Source clock: one rise every two cycles
	always @(posedge sys_clk) srcClkLevel <= !srcClkLevel;
	ocds_output_channels dut (.sys_clk(sys_clk), .arst_n(arst_n), .srcClkLevel(srcClkLevel),
		.sysrefRequest(sysrefRequest), .outputDriverEnable(en), .channelMuxSel(sel),
		.channelDivideRatio(cdr), .channelStaticDelay(cdd), .sysrefDivideRatio(sdr),
		.sysrefStaticDelay(sdd), .sysrefDigitalDelay(sdg), .analogDelayStage(adl),
		.pairSysrefReplicaEnable(rep), .generalPinOutputEnable(pinEn), .regWrEn(regWrEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(rd), .positiveOutputLeg(pos),
		.negativeOutputLeg(neg), .outputDriverOe(oe), .generalPinOne(p1),
		.generalPinOneOe(p1oe), .generalPinTwo(p2), .generalPinTwoOe(p2oe),
		.dividerPowered(dPw), .sysrefPowered(sPw));
	ocds_rx_model rx0 (.sys_clk(sys_clk), .arst_n(arst_n), .clkIn(pos[watch]), .periodLen(per0));
	ocds_rx_model rx1 (.sys_clk(sys_clk), .arst_n(arst_n), .clkIn(p1), .periodLen(per1));
	ocds_rx_model rx2 (.sys_clk(sys_clk), .arst_n(arst_n), .clkIn(p2), .periodLen(per2));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			fail_count++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regWrEn   <= 1'h1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge sys_clk);
		regWrEn <= 1'h0;
	endtask
	task automatic regRead(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		cyc(2);
		d = rd;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#(50 * 5000);
		fail_count++;
		stop_test;
	end
	initial
	begin
		logic [7:0]  d;
		logic [15:0] hi;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'h1;
		regRead(REQ_CTRL_ADDR, d);
		check("reg reset", d, REQ_CTRL_RESET);
		regWrite(REQ_CTRL_ADDR, {2'h0, REQ_MODE_RESAMPLE, REQ_SEL_SOURCE, 2'h0});
		regRead(REQ_CTRL_ADDR, d);
		check("reg mode", d, 8'h30);
		regRead(8'h1b, d);
		check("unmapped", d, 8'h00);
		$display("register test done");
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sys_clk);
			watch <= chs[i];
			sel[chs[i]] <= codes[i];
			cyc(90);
			check("period", per0, exps[i]);
			check("leg pair", neg[chs[i]], !pos[chs[i]]);
		end
		@(posedge sys_clk);
		sel[0] <= CM_STATIC_DC;
		sel[2] <= CM_SYSREF;
		cyc(3);
		check("dc legs", {pos[0], neg[0], pos[2], neg[2]}, 16'h5);
		$display("mux test done");
		@(posedge sys_clk);
		en[0] <= 1'h0;
		en[4] <= 1'h0;
		cyc(2);
		check("oe off", oe[0], 1'h0);
		check("power single", dPw[0], 1'h0);
		check("sysref power off", sPw[0], 1'h0);
		check("power group one", dPw[4], 1'h1);
		@(posedge sys_clk);
		en[5] <= 1'h0;
		cyc(2);
		check("power group none", dPw[4], 1'h0);
		@(posedge sys_clk);
		en    <= 16'hffff;
		$display("power test done");
		rep   <= 7'h01;
		pinEn <= 2'h1;
		cyc(100);
		check("pin one oe", p1oe, 1'h1);
		check("pin two oe", p2oe, 1'h0);
		check("replica period", per1, 16'h18);
		check("replica two period", per2, 16'h18);
		$display("replica test done");
		for (int m = 0; m < 2; m++)
		begin
			regWrite(REQ_CTRL_ADDR, (m == 0) ? 8'h30 : 8'h00);
			@(posedge sys_clk);
			sysrefRequest <= 1'h1;
			cyc(4);
			hi = 16'h0000;
			repeat (40)
			begin
				cyc(1);
				hi = hi + {15'h0000, p1};
			end
			check("restart holds", hi, 16'h0000);
			@(posedge sys_clk);
			sysrefRequest <= 1'h0;
			cyc(100);
			check("restart release", per1, 16'h18);
		end
		$display("restart test done");
		@(posedge sys_clk);
		pinEn <= 2'h3;
		cyc(2);
		check("pin two on", p2oe, 1'h1);
		@(posedge sys_clk);
		en[0] <= 1'h0;
		cyc(3);
		check("no source", p1oe, 1'h0);
		check("no source two", p2oe, 1'h0);
		$display("source test done");
		stop_test;
	end
endmodule
`default_nettype wire
